/* hw/port_pin_pkg.sv */
package port_pin_pkg;

  localparam int unsigned PORT_WIDTH = 8;

  // Register indices. The printed offset 0x0253 is not a multiple of four,
  // so every offset is held as an index and the byte address is four times it.
  localparam logic [11:0] IDX_OUTPUT_DATA = 12'h250;
  localparam logic [11:0] IDX_PIN_INPUT = 12'h251;
  localparam logic [11:0] IDX_DIRECTION = 12'h252;
  localparam logic [11:0] IDX_DRIVE_STRENGTH = 12'h253;
  localparam logic [11:0] IDX_PULL_ENABLE = 12'h254;
  localparam logic [11:0] IDX_PULL_POLARITY = 12'h255;
  localparam logic [11:0] IDX_OPEN_DRAIN = 12'h256;

  localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_DRIVE_STRENGTH = 8'h00;
  localparam logic [7:0] RST_PULL_ENABLE = 8'h00;
  localparam logic [7:0] RST_PULL_POLARITY = 8'h00;
  localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_PIN_SAMPLE = 8'h00;

  // Pin positions of the routed peripherals.
  localparam int unsigned SPI_PIN_LO = 2;
  localparam int unsigned SPI_PIN_HI = 5;
  localparam int unsigned TX_PIN = 1;
  localparam int unsigned RX_PIN = 0;

  typedef struct packed {
    logic spi_enable;
    logic [3:0] spi_dir;
    logic [3:0] spi_out;
    logic can_enable;
    logic can_active;
    logic can_tx;
    logic async_enable;
    logic async_tx;
  } periph_ctl_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] reduced_drive;
    logic [7:0] pull_up_en;
    logic [7:0] pull_down_en;
  } pad_ctl_s;

endpackage : port_pin_pkg

/* hw/pin_input_sync.sv */
`timescale 1ns/10ps
// Three-stage sampler: a change is taken once the second and third stages agree.
module pin_input_sync
  import port_pin_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_s;

  sync_state_s st_r;
  sync_state_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.level[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_level = st_r.level;

endmodule : pin_input_sync

/* hw/port_pin_config_bank.sv */
`timescale 1ns/10ps
// Summary of operation
// - Pin input register always returns the sampled pin level, any direction.
// - Pin input register is read-only; writes change nothing.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Enabled serial peripheral forces direction of pins 5..2; stored bits kept.
// - Enabled CAN or async serial forces pin 1 output; stored bit kept.
// - Enabled CAN or async serial forces pin 0 input; stored bit kept.
// - Drive bit 1 selects reduced drive, about one fifth; 0 selects full.
// - Drive bit ignored on inputs; applies to outputs whatever drives them.
// - Pull-enable bit 1 enables the pull device on an input pin.
// - On an output pin pull-enable acts only in open-drain mode.
// - Polarity bit 1 selects pull-down, 0 selects pull-up.
// - With CAN active, pull-down choice on the receive pin has no effect.
// - Data read gives stored bit where the stored direction bit is 1, pin level where it is 0.
// - Open-drain outputs drive low for 0, float for 1; inputs unaffected.
module port_pin_config_bank
  import port_pin_pkg::*;
#(
  parameter int unsigned WIDTH = PORT_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire periph_ctl_s periph,
  input wire logic [WIDTH-1:0] pin_in,
  output pad_ctl_s pad
);

  initial begin
    if (WIDTH != 8) begin
      $error("port_pin_config_bank serves exactly eight pins");
    end
  end

  typedef struct packed {
    logic [7:0] out_data;
    logic [7:0] direction;
    logic [7:0] drive;
    logic [7:0] pull_en;
    logic [7:0] pull_pol;
    logic [7:0] open_drain;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    pad_ctl_s pad;
  } bank_state_s;

  bank_state_s st_r;
  bank_state_s st_nxt;
  logic [7:0] pin_level;
  logic [11:0] reg_idx;
  logic access;
  logic wr_en;
  logic mapped;
  logic [7:0] eff_out_en;
  logic [7:0] drive_val;
  logic [7:0] read_back;

  pin_input_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(pin_in),
    .pin_level(pin_level)
  );

  assign reg_idx = paddr[13:2];
  // The slave answers one cycle after the first access-phase cycle; pready is a register.
  assign access = psel && penable && !st_r.ready;
  // A write lands at the edge where pready is sampled high, as the master expects.
  assign wr_en = psel && penable && st_r.ready && pwrite && pstrb[0];

  always_comb begin
    mapped = 1'b1;
    read_back = 8'h00;
    unique case (reg_idx)
      IDX_OUTPUT_DATA: begin
        // Pins whose stored direction bit is 1 read back the stored bit, the others the sampled pin.
        read_back = (st_r.direction & st_r.out_data) | (~st_r.direction & pin_level);
      end
      IDX_PIN_INPUT: read_back = pin_level;
      IDX_DIRECTION: read_back = st_r.direction;
      IDX_DRIVE_STRENGTH: read_back = st_r.drive;
      IDX_PULL_ENABLE: read_back = st_r.pull_en;
      IDX_PULL_POLARITY: read_back = st_r.pull_pol;
      IDX_OPEN_DRAIN: read_back = st_r.open_drain;
      default: mapped = 1'b0;
    endcase
  end

  // Effective direction: stored bits, overridden by enabled peripherals.
  always_comb begin
    eff_out_en = st_r.direction;
    drive_val = st_r.out_data;
    if (periph.spi_enable) begin
      eff_out_en[SPI_PIN_HI:SPI_PIN_LO] = periph.spi_dir;
      drive_val[SPI_PIN_HI:SPI_PIN_LO] = periph.spi_out;
    end
    if (periph.can_enable || periph.async_enable) begin
      eff_out_en[TX_PIN] = 1'b1;
      eff_out_en[RX_PIN] = 1'b0;
      drive_val[TX_PIN] = periph.can_enable ? periph.can_tx : periph.async_tx;
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = access;
    st_nxt.slverr = access && !mapped;
    if (access && !pwrite) begin
      st_nxt.rdata = {24'h000000, read_back};
    end
    if (!access) begin
      st_nxt.slverr = 1'b0;
    end
    if (wr_en) begin
      // The pin input index has no write case, so a write there is dropped.
      unique case (reg_idx)
        IDX_OUTPUT_DATA: st_nxt.out_data = pwdata[7:0];
        IDX_DIRECTION: st_nxt.direction = pwdata[7:0];
        IDX_DRIVE_STRENGTH: st_nxt.drive = pwdata[7:0];
        IDX_PULL_ENABLE: st_nxt.pull_en = pwdata[7:0];
        IDX_PULL_POLARITY: st_nxt.pull_pol = pwdata[7:0];
        IDX_OPEN_DRAIN: st_nxt.open_drain = pwdata[7:0];
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    for (int i = 0; i < 8; i++) begin
      logic pull_on;
      logic od_pin;
      pull_on = 1'b0;
      od_pin = eff_out_en[i] && st_r.open_drain[i];
      // Open-drain drives only a 0; a 1 leaves the pin floating.
      st_nxt.pad.oe[i] = eff_out_en[i] && !(od_pin && drive_val[i]);
      st_nxt.pad.out[i] = drive_val[i];
      // Reduced drive matters only while the pin drives, whoever drives it.
      st_nxt.pad.reduced_drive[i] = eff_out_en[i] && st_r.drive[i];
      pull_on = st_r.pull_en[i] && (!eff_out_en[i] || od_pin);
      st_nxt.pad.pull_down_en[i] = pull_on && st_r.pull_pol[i];
      st_nxt.pad.pull_up_en[i] = pull_on && !st_r.pull_pol[i];
    end
    // The receive pin never takes a pull-down while CAN is active.
    if (periph.can_active) begin
      st_nxt.pad.pull_down_en[RX_PIN] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.out_data <= RST_OUTPUT_DATA;
      st_r.direction <= RST_DIRECTION;
      st_r.drive <= RST_DRIVE_STRENGTH;
      st_r.pull_en <= RST_PULL_ENABLE;
      st_r.pull_pol <= RST_PULL_POLARITY;
      st_r.open_drain <= RST_OPEN_DRAIN;
      st_r.rdata <= 32'h00000000;
      st_r.ready <= 1'b0;
      st_r.slverr <= 1'b0;
      st_r.pad <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.slverr;
  assign pad = st_r.pad;

  a_input_reads: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && reg_idx == IDX_PIN_INPUT) |=> prdata == {24'h000000, $past(pin_level)})
    else $error("pin input read mismatch");

  a_input_ro: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && reg_idx == IDX_PIN_INPUT) |=> $stable(st_r.direction) && $stable(st_r.out_data)
      && $stable(st_r.drive) && $stable(st_r.pull_en))
    else $error("write to pin input changed state");

  a_dir_output: assert property (@(posedge pclk) disable iff (!presetn)
    (!periph.spi_enable && !periph.can_enable && !periph.async_enable
      && st_r.direction[7] && !st_r.open_drain[7]) |=> pad.oe[7])
    else $error("direction bit did not enable output");

  a_spi_keeps_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (periph.spi_enable && !wr_en) |=> $stable(st_r.direction))
    else $error("serial peripheral changed stored direction");

  a_tx_forced: assert property (@(posedge pclk) disable iff (!presetn)
    (periph.can_enable && !st_r.open_drain[TX_PIN]) |=> pad.oe[TX_PIN])
    else $error("transmit pin not forced to output");

  a_rx_forced: assert property (@(posedge pclk) disable iff (!presetn)
    (periph.can_enable || periph.async_enable) |=> !pad.oe[RX_PIN])
    else $error("receive pin not forced to input");

  a_drive_input: assert property (@(posedge pclk) disable iff (!presetn)
    (pad.reduced_drive & ~$past(eff_out_en)) == 8'h00)
    else $error("reduced drive on input");

  a_pull_excl: assert property (@(posedge pclk) disable iff (!presetn)
    (pad.pull_up_en & pad.pull_down_en) == 8'h00)
    else $error("both pull devices on");

  a_can_pulldown: assert property (@(posedge pclk) disable iff (!presetn)
    $past(periph.can_active) |-> !pad.pull_down_en[RX_PIN])
    else $error("pull-down on receive pin while CAN active");

  a_od_float: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.direction[6] && st_r.open_drain[6] && st_r.out_data[6]) |=> !pad.oe[6])
    else $error("open-drain one was driven");

  // The bus handshake is checked in steps: setup, the taken cycle and the answer.
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_taken;
    psel && penable && !pready;
  endsequence

  sequence s_answer;
    psel && penable && pready;
  endsequence

  a_setup_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> !pready || !psel)
    else $error("answer came before the access phase");

  a_bus_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_taken |=> pready)
    else $error("no answer one cycle after the taken cycle");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");

  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    s_taken ##0 !mapped |=> pslverr)
    else $error("unmapped index gave no error");

  a_strobe_off: assert property (@(posedge pclk) disable iff (!presetn)
    s_answer ##0 (pwrite && !pstrb[0]) |=> $stable(st_r.direction) && $stable(st_r.pull_en))
    else $error("write without strobe changed state");

  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_answer ##0 (pwrite && pstrb[0] && reg_idx == IDX_DIRECTION)
      |=> st_r.direction == $past(pwdata[7:0]))
    else $error("direction write lost");

  a_data_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_answer ##0 (pwrite && pstrb[0] && reg_idx == IDX_OUTPUT_DATA)
      |=> st_r.out_data == $past(pwdata[7:0]))
    else $error("data write lost");

  a_drive_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_answer ##0 (pwrite && pstrb[0] && reg_idx == IDX_DRIVE_STRENGTH)
      |=> st_r.drive == $past(pwdata[7:0]))
    else $error("drive write lost");

  a_pull_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_answer ##0 (pwrite && pstrb[0] && reg_idx == IDX_PULL_ENABLE)
      |=> st_r.pull_en == $past(pwdata[7:0]))
    else $error("pull enable write lost");

  a_pol_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_answer ##0 (pwrite && pstrb[0] && reg_idx == IDX_PULL_POLARITY)
      |=> st_r.pull_pol == $past(pwdata[7:0]))
    else $error("polarity write lost");

  a_od_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_answer ##0 (pwrite && pstrb[0] && reg_idx == IDX_OPEN_DRAIN)
      |=> st_r.open_drain == $past(pwdata[7:0]))
    else $error("open-drain write lost");

  a_input_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.direction == 8'h00 && !periph.spi_enable && !periph.can_enable
      && !periph.async_enable) |=> pad.oe == 8'h00)
    else $error("input pin was driven");

  a_spi_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (periph.spi_enable && st_r.open_drain[SPI_PIN_HI:SPI_PIN_LO] == 4'h0)
      |=> pad.oe[SPI_PIN_HI:SPI_PIN_LO] == $past(periph.spi_dir))
    else $error("serial peripheral direction not applied");

  a_tx_value: assert property (@(posedge pclk) disable iff (!presetn)
    periph.can_enable |=> pad.out[TX_PIN] == $past(periph.can_tx))
    else $error("transmit pin does not carry the CAN value");

  a_full_drive: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.drive == 8'h00 |=> pad.reduced_drive == 8'h00)
    else $error("reduced drive without a drive bit");

  a_pull_off: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.pull_en == 8'h00 |=> (pad.pull_up_en | pad.pull_down_en) == 8'h00)
    else $error("pull device on without enable");

  a_pull_pushpull: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.direction[7] && !st_r.open_drain[7]) |=> !pad.pull_up_en[7] && !pad.pull_down_en[7])
    else $error("pull device on a push-pull output");

  a_pol_up: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.pull_en[7] && !st_r.direction[7] && !st_r.pull_pol[7]) |=> pad.pull_up_en[7])
    else $error("pull-up not applied");

  a_data_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && reg_idx == IDX_OUTPUT_DATA && st_r.direction == 8'hff)
      |=> prdata[7:0] == $past(st_r.out_data))
    else $error("output data read back wrong");

  a_od_low: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.direction[6] && st_r.open_drain[6] && !st_r.out_data[6]) |=> pad.oe[6] && !pad.out[6])
    else $error("open-drain zero not driven low");

endmodule : port_pin_config_bank

/* sim/pin_partner.sv */
`timescale 1ns/10ps
// Stands for the pins and whatever is wired to them outside the port.
// An external driver wins over the port, which is how a shorted output is shown.
module pin_partner
  import port_pin_pkg::*;
(
  input wire pad_ctl_s pad,
  input wire logic [7:0] ext_val,
  input wire logic ext_en,
  output logic [7:0] pin_in
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en) pin_in[i] = ext_val[i];
      else if (pad.oe[i]) pin_in[i] = pad.out[i];
      else if (pad.pull_up_en[i]) pin_in[i] = 1'b1;
      else if (pad.pull_down_en[i]) pin_in[i] = 1'b0;
      else pin_in[i] = ext_val[i];
    end
  end
endmodule : pin_partner

/* sim/port_pin_config_bank_test.sv */
`timescale 1ns/10ps
module port_pin_config_bank_test
  import port_pin_pkg::*;
;
  typedef struct packed {
    logic [7:0] dir, dat, drv, pe, pol, od;
    periph_ctl_s p;
    logic [7:0] oe, ob, rd, pu, pd;
  } row_s;
  // Columns: direction, data, drive, pull enable, polarity, open drain, peripherals,
  // then expected oe, driven out bits, reduced drive, pull-up, pull-down.
  row_s rows [7] = '{
    '{8'h0f, 8'h05, 8'hff, 8'hff, 8'h0f, 8'h00, 14'h0000, 8'h0f, 8'h05, 8'h0f, 8'hf0, 8'h00},
    '{8'hff, 8'ha5, 8'h00, 8'hff, 8'hf0, 8'h00, 14'h0000, 8'hff, 8'ha5, 8'h00, 8'h00, 8'h00},
    '{8'hff, 8'h0f, 8'h00, 8'hff, 8'hf0, 8'hff, 14'h0000, 8'hf0, 8'h00, 8'h00, 8'h0f, 8'hf0},
    '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 14'h3500, 8'h28, 8'h20, 8'h28, 8'h00, 8'h00},
    '{8'h3c, 8'h00, 8'h00, 8'h3c, 8'h00, 8'h00, 14'h2aa0, 8'h14, 8'h14, 8'h00, 8'h28, 8'h00},
    '{8'h01, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 14'h001c, 8'h02, 8'h02, 8'h00, 8'h00, 8'hfc},
    '{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 14'h0002, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}
  };
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, ext_en, rerr;
  logic [31:0] paddr, pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic [7:0] pin_in, ext_val;
  periph_ctl_s periph;
  pad_ctl_s pad;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  port_pin_config_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph(periph), .pin_in(pin_in), .pad(pad));
  pin_partner pins (.pad(pad), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  always #4 pclk = ~pclk;

  task give_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // The slave answers after one wait state; the master still waits on pready.
  task apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {18'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task cfg(input row_s r);
    apb(1'b1, IDX_DIRECTION, r.dir);
    apb(1'b1, IDX_OUTPUT_DATA, r.dat);
    apb(1'b1, IDX_DRIVE_STRENGTH, r.drv);
    apb(1'b1, IDX_PULL_ENABLE, r.pe);
    apb(1'b1, IDX_PULL_POLARITY, r.pol);
    apb(1'b1, IDX_OPEN_DRAIN, r.od);
  endtask : cfg

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, ext_en} = '0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    ext_val = 8'h00;
    periph = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    check("pad after reset", pad, 40'h0);
    for (int i = 'h251; i <= 'h256; i++) begin
      apb(1'b0, i[11:0], 8'h00);
      check("reset value", rdata, 32'h0);
    end
    foreach (rows[k]) begin
      periph <= rows[k].p;
      cfg(rows[k]);
      repeat (3) @(posedge pclk);
      check("oe", pad.oe, rows[k].oe);
      check("out", pad.out & pad.oe, rows[k].ob);
      check("drive", pad.reduced_drive, rows[k].rd);
      check("pull up", pad.pull_up_en, rows[k].pu);
      check("pull down", pad.pull_down_en, rows[k].pd);
      apb(1'b0, IDX_DIRECTION, 8'h00);
      check("direction kept", rdata, {24'h0, rows[k].dir});
    end
    // An outside driver fights the high outputs, as a short would.
    periph <= '0;
    ext_val <= 8'h30;
    ext_en <= 1'b1;
    cfg('{8'h0f, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 14'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0});
    repeat (8) @(posedge pclk);
    apb(1'b0, IDX_PIN_INPUT, 8'h00);
    check("pin input", rdata, 32'h30);
    apb(1'b0, IDX_OUTPUT_DATA, 8'h00);
    check("data read", rdata, 32'h3a);
    apb(1'b1, IDX_PIN_INPUT, 8'hff);
    check("pin input write error", rerr, 1'b0);
    apb(1'b0, IDX_PIN_INPUT, 8'h00);
    check("pin input after write", rdata, 32'h30);
    apb(1'b0, 12'h257, 8'h00);
    check("unmapped error", rerr, 1'b1);
    give_verdict();
  end
endmodule : port_pin_config_bank_test
